// file: hw/fsi_pkg.sv
package fsi_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int NUM_CHAN   = 4;
  localparam int CHAN_W     = (NUM_CHAN > 1) ? $clog2(NUM_CHAN) : 1;
  localparam int NUM_PATH   = 2;
  localparam int PATH_W     = 11;
  localparam int PATH_PAD   = ((PATH_W + 7) / 8) * 8;
  localparam int OUT_W      = 13;
  localparam int OUT_PAD    = ((OUT_W + 7) / 8) * 8;
  localparam int USER_W     = 4;
  localparam int FSEL_W     = 3;
  localparam int CFG_PAD    = ((FSEL_W + 7) / 8) * 8;
  localparam int CFG_DEPTH  = 8;
  localparam int CFG_PTR_W  = 3;
  localparam int CFG_AFULL  = CFG_DEPTH - 2;
  localparam int RATE_W     = 4;
  localparam int RSLOT_W    = 2;
  localparam int TUSER_W    = USER_W + CHAN_W;
  localparam int OTUSER_W   = TUSER_W + 1;
  localparam int RST_HOLD   = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [FSEL_W-1:0]  FSEL_RST = 3'h0;
  localparam logic [RATE_W-1:0]  ONE_RATE = 4'h1;

  typedef enum logic [1:0] {
    FSI_NONE   = 2'b00,
    FSI_INTERP = 2'b01,
    FSI_DECIM  = 2'b10
  } fsi_rate_t;

  typedef struct packed {
    logic [NUM_PATH*PATH_PAD-1:0] data;
    logic [TUSER_W-1:0]           user;
    logic                         last;
  } fsi_in_t;

  typedef struct packed {
    logic [NUM_PATH*OUT_PAD-1:0] data;
    logic [OTUSER_W-1:0]         user;
    logic                        last;
  } fsi_out_t;

  typedef struct packed {
    logic [CFG_PAD-1:0] data;
    logic               last;
  } fsi_cfg_t;

endpackage : fsi_pkg

// file: hw/fsi_core.sv
`timescale 1ns/1ns
// Operation
// - Transfer only when valid and ready high
// - Channel without ready accepts every valid beat
// - Input ready while output slot free; output backpressure stalls input
// - Paths side by side, sign-extended to bytes
// - Vector last marks final interleaved channel with no rate change
// - Packet mode carries last with sample latency
// - Channel id sits below user field
// - User field passes with sample latency
// - Channel id width is ceil_log_two channels
// - Data-valid bit at sideband LSB
// - No rate change passes sideband unchanged
// - Interpolation copies sideband onto block's last
// - Decimation: first sideband, ORed last marker
// - Config packet per channel or single value
// - Consuming config activates reloaded sets
// - Samples never stall for missing config
// - Full reload slots hold reload ready low
// - Vector sync consumes at first channel/phase
// - Packet sync consumes after input last
// - Config buffered, ready drops near full
// - Misplaced config last flagged on event in per-channel packet mode
// - Config data zero padded to bytes
// - Events pulse one cycle per anomaly
// - Active-low reset held two cycles
module fsi_core import fsi_pkg::*; (
  // Clock and reset
  input  wire  logic                      sys_clk,
  input  wire  logic                      rst,
  input  wire  logic                      aresetn_n,
  input  wire  logic                      clk_en,
  // Configuration straps
  input  wire  fsi_rate_t                 rate_mode,
  input  wire  logic [RATE_W-1:0]         rate_fac,
  input  wire  logic                      pkt_last_mode,
  input  wire  logic                      pkt_sync,
  input  wire  logic                      cfg_single,
  input  wire  logic                      out_has_ready,
  // Input sample stream
  input  wire  logic                      s_data_tvalid,
  input  wire  fsi_in_t                   s_data_pay,
  output logic                            s_data_tready,
  // Output sample stream
  output logic                            m_data_tvalid,
  output fsi_out_t                        m_data_pay,
  input  wire  logic                      m_data_tready,
  // Configuration stream
  input  wire  logic                      s_cfg_tvalid,
  input  wire  fsi_cfg_t                  s_cfg_pay,
  output logic                            s_cfg_tready,
  // Reload slot handshake
  input  wire  logic                      reload_done,
  output logic                            reload_tready,
  output logic [NUM_CHAN*FSEL_W-1:0]      fsel_out,
  output logic                            reload_activate,
  // Events
  output logic                            ev_cfg_last_missing,
  output logic                            ev_cfg_last_unexp
);

  // ****************************************
  // Handshake terms
  // ****************************************
  logic out_rdy;
  logic in_fire;
  logic cfg_fire;
  logic adv;
  assign out_rdy  = m_data_tready | ~out_has_ready;
  assign in_fire  = s_data_tvalid & s_data_tready;
  assign cfg_fire = s_cfg_tvalid & s_cfg_tready;
  assign adv      = clk_en & aresetn_n;

  // ****************************************
  // Sample path state
  // ****************************************
  logic                        in_rdy_ff, nxt_in_rdy;
  logic                        ov_ff, nxt_ov;
  fsi_out_t                    op_ff, nxt_op;
  logic [RATE_W-1:0]           ph_ff, nxt_ph;
  logic [TUSER_W-1:0]          hold_user_ff, nxt_hold_user;
  logic                        hold_last_ff, nxt_hold_last;
  logic                        flushed_ff, nxt_flushed;
  logic [CHAN_W-1:0]           chan_ff, nxt_chan;
  logic [NUM_PATH*OUT_PAD-1:0] ext_data;
  logic                        first_vec;

  // Sign extension per path; input pad bits are ignored
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PATH; gp++) begin : g_path
      assign ext_data[gp*OUT_PAD +: OUT_PAD] =
        OUT_PAD'($signed(s_data_pay.data[gp*PATH_PAD +: PATH_W]));
    end
  endgenerate

  assign first_vec = (chan_ff == '0) &&
                     ((rate_mode != FSI_DECIM) || (ph_ff == '0));

  always_comb begin
    nxt_in_rdy    = in_rdy_ff;
    nxt_ov        = ov_ff;
    nxt_op        = op_ff;
    nxt_ph        = ph_ff;
    nxt_hold_user = hold_user_ff;
    nxt_hold_last = hold_last_ff;
    nxt_flushed   = flushed_ff;
    nxt_chan      = chan_ff;
    if (!aresetn_n) begin
      nxt_ov      = 1'b0;
      nxt_ph      = '0;
      nxt_chan    = '0;
      nxt_flushed = 1'b0;
      nxt_in_rdy  = 1'b0;
    end else if (clk_en) begin
      if (ov_ff && out_rdy) begin
        nxt_ov = 1'b0;
      end
      if (in_fire) begin
        nxt_ov       = 1'b1;
        nxt_op.data  = ext_data;
        nxt_flushed  = 1'b1;
        nxt_chan     = (chan_ff == CHAN_W'(NUM_CHAN - 1)) ? '0 : chan_ff + 1'b1;
        unique case (rate_mode)
          FSI_INTERP: begin
            nxt_op.user = {s_data_pay.user, 1'b1};
            nxt_op.last = s_data_pay.last;
          end
          FSI_DECIM: begin
            nxt_ph = (ph_ff == rate_fac - ONE_RATE) ? '0 : ph_ff + 1'b1;
            if (ph_ff == '0) begin
              nxt_hold_user = s_data_pay.user;
              nxt_hold_last = s_data_pay.last;
            end else begin
              nxt_hold_last = hold_last_ff | s_data_pay.last;
            end
            nxt_ov = (ph_ff == rate_fac - ONE_RATE);
            nxt_op.user = {(ph_ff == '0) ? s_data_pay.user : hold_user_ff, 1'b1};
            nxt_op.last = (ph_ff == '0) ? s_data_pay.last
                                        : (hold_last_ff | s_data_pay.last);
          end
          default: begin
            nxt_op.user = {s_data_pay.user, flushed_ff};
            nxt_op.last = pkt_last_mode ? s_data_pay.last
                          : (chan_ff == CHAN_W'(NUM_CHAN - 1));
          end
        endcase
      end
      // Ready is registered, so only a free output slot, or an output without ready, may promise room
      nxt_in_rdy = ~nxt_ov | ~out_has_ready;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_rdy_ff    <= 1'b0;
      ov_ff        <= 1'b0;
      op_ff        <= '0;
      ph_ff        <= '0;
      hold_user_ff <= '0;
      hold_last_ff <= 1'b0;
      flushed_ff   <= 1'b0;
      chan_ff      <= '0;
    end else begin
      in_rdy_ff    <= nxt_in_rdy;
      ov_ff        <= nxt_ov;
      op_ff        <= nxt_op;
      ph_ff        <= nxt_ph;
      hold_user_ff <= nxt_hold_user;
      hold_last_ff <= nxt_hold_last;
      flushed_ff   <= nxt_flushed;
      chan_ff      <= nxt_chan;
    end
  end

  assign s_data_tready = in_rdy_ff;
  assign m_data_tvalid = ov_ff;
  assign m_data_pay    = op_ff;

  // ****************************************
  // Configuration buffer and consumption
  // ****************************************
  logic [FSEL_W-1:0]              cfg_mem_ff [CFG_DEPTH];
  logic [FSEL_W-1:0]              nxt_cfg_mem [CFG_DEPTH];
  logic [CFG_PTR_W:0]             cnt_ff, nxt_cnt;
  logic [CFG_PTR_W-1:0]           wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CHAN_W-1:0]              bc_ff, nxt_bc;
  logic [CFG_PTR_W:0]             pk_ff, nxt_pk;
  logic                           cfg_rdy_ff, nxt_cfg_rdy;
  logic [NUM_CHAN*FSEL_W-1:0]     fsel_ff, nxt_fsel;
  logic                           seen_last_ff, nxt_seen_last;
  logic                           act_ff, nxt_act;
  logic                           evm_ff, nxt_evm, evu_ff, nxt_evu;
  logic [RSLOT_W:0]               slots_ff, nxt_slots;
  logic                           rrdy_ff, nxt_rrdy;
  logic                           pkt_end, consume;
  logic [CFG_PTR_W:0]             plen;

  assign plen    = cfg_single ? (CFG_PTR_W+1)'(1) : (CFG_PTR_W+1)'(NUM_CHAN);
  assign pkt_end = cfg_single || (bc_ff == CHAN_W'(NUM_CHAN - 1));

  // Packets wait; samples never stall on config
  assign consume = in_fire && (pk_ff != '0) && first_vec &&
                   (!pkt_sync || seen_last_ff);

  always_comb begin
    nxt_cfg_mem   = cfg_mem_ff;
    nxt_cnt       = cnt_ff;
    nxt_wp        = wp_ff;
    nxt_rp        = rp_ff;
    nxt_bc        = bc_ff;
    nxt_pk        = pk_ff;
    nxt_cfg_rdy   = cfg_rdy_ff;
    nxt_fsel      = fsel_ff;
    nxt_seen_last = seen_last_ff;
    nxt_act       = 1'b0;
    nxt_evm       = 1'b0;
    nxt_evu       = 1'b0;
    nxt_slots     = slots_ff;
    nxt_rrdy      = rrdy_ff;
    if (!aresetn_n) begin
      nxt_cnt = '0; nxt_wp = '0; nxt_rp = '0; nxt_bc = '0; nxt_pk = '0;
      nxt_seen_last = 1'b0; nxt_slots = '0; nxt_cfg_rdy = 1'b0; nxt_rrdy = 1'b0;
    end else if (clk_en) begin
      if (cfg_fire) begin
        nxt_cfg_mem[wp_ff] = s_cfg_pay.data[FSEL_W-1:0];
        nxt_wp  = wp_ff + 1'b1;
        nxt_cnt = nxt_cnt + 1'b1;
        nxt_bc  = pkt_end ? '0 : bc_ff + 1'b1;
        if (pkt_end) begin
          nxt_pk  = nxt_pk + 1'b1;
        end
        if (!cfg_single) begin
          nxt_evm = pkt_end & ~s_cfg_pay.last;
          nxt_evu = ~pkt_end & s_cfg_pay.last;
        end
      end
      if (in_fire && s_data_pay.last) begin
        nxt_seen_last = 1'b1;
      end
      if (consume) begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          nxt_fsel[c*FSEL_W +: FSEL_W] =
            cfg_mem_ff[CFG_PTR_W'(rp_ff + (cfg_single ? 0 : c))];
        end
        nxt_rp        = rp_ff + plen[CFG_PTR_W-1:0];
        nxt_cnt       = nxt_cnt - plen;
        nxt_pk        = nxt_pk - 1'b1;
        nxt_seen_last = s_data_pay.last;
        nxt_act       = 1'b1;
        nxt_slots     = (RSLOT_W+1)'(reload_done && rrdy_ff);
      end else if (reload_done && rrdy_ff) begin
        nxt_slots = slots_ff + 1'b1;
      end
      nxt_cfg_rdy = (nxt_cnt < (CFG_PTR_W+1)'(CFG_AFULL));
      nxt_rrdy    = (nxt_slots != (RSLOT_W+1)'(1 << RSLOT_W));
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CFG_DEPTH; i++) begin
        cfg_mem_ff[i] <= FSEL_RST;
      end
      cnt_ff       <= '0;
      wp_ff        <= '0;
      rp_ff        <= '0;
      bc_ff        <= '0;
      pk_ff        <= '0;
      cfg_rdy_ff   <= 1'b0;
      fsel_ff      <= '0;
      seen_last_ff <= 1'b0;
      act_ff       <= 1'b0;
      evm_ff       <= 1'b0;
      evu_ff       <= 1'b0;
      slots_ff     <= '0;
      rrdy_ff      <= 1'b0;
    end else begin
      cfg_mem_ff   <= nxt_cfg_mem;
      cnt_ff       <= nxt_cnt;
      wp_ff        <= nxt_wp;
      rp_ff        <= nxt_rp;
      bc_ff        <= nxt_bc;
      pk_ff        <= nxt_pk;
      cfg_rdy_ff   <= nxt_cfg_rdy;
      fsel_ff      <= nxt_fsel;
      seen_last_ff <= nxt_seen_last;
      act_ff       <= nxt_act;
      evm_ff       <= nxt_evm;
      evu_ff       <= nxt_evu;
      slots_ff     <= nxt_slots;
      rrdy_ff      <= nxt_rrdy;
    end
  end

  assign s_cfg_tready        = cfg_rdy_ff;
  assign fsel_out            = fsel_ff;
  assign reload_activate     = act_ff;
  assign reload_tready       = rrdy_ff;
  assign ev_cfg_last_missing = evm_ff;
  assign ev_cfg_last_unexp   = evu_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  out_hold_a: assert property (ov_ff && !out_rdy && clk_en && aresetn_n
    |=> ov_ff && $stable(op_ff))
    else $error("output beat dropped under backpressure");
  in_stall_a: assert property (ov_ff && !out_rdy && aresetn_n && clk_en |=> !s_data_tready)
    else $error("input not stalled");
  cen_hold_a: assert property (!clk_en && aresetn_n |=> $stable(op_ff) && $stable(fsel_ff))
    else $error("state moved with clock enable low");
  ev_pulse_a: assert property (ev_cfg_last_missing |=> !ev_cfg_last_missing || $past(cfg_fire))
    else $error("event longer than one anomaly");
  cfg_full_a: assert property (cnt_ff >= (CFG_PTR_W+1)'(CFG_AFULL) |-> !s_cfg_tready)
    else $error("config ready with buffer near full");
  act_cause_a: assert property (reload_activate |-> $past(consume))
    else $error("activate without consumption");
  pkt_sync_a: assert property (in_fire && clk_en && pkt_sync && !seen_last_ff
    |=> !reload_activate)
    else $error("consumed before input last");
  reload_blk_a: assert property (slots_ff == (RSLOT_W+1)'(1 << RSLOT_W) |-> !reload_tready)
    else $error("reload ready with slots full");
  last_pass_a: assert property (in_fire && adv && pkt_last_mode && rate_mode == FSI_NONE
    |=> m_data_pay.last == $past(s_data_pay.last))
    else $error("last marker not carried");

  cons_c: cover property (consume);
  bp_c:   cover property (ov_ff && !out_rdy);
  evu_c:  cover property (ev_cfg_last_unexp);

endmodule : fsi_core

// file: dv/fsi_sink.sv
`timescale 1ns/1ns
// ****************************************
// Downstream sample consumer
// ****************************************
module fsi_sink import fsi_pkg::*; (
  // Clock and reset
  input  wire logic     sys_clk,
  input  wire logic     rst,
  // Stall control
  input  wire logic     stall,
  input  wire logic     no_ready,
  // Output sample stream
  input  wire logic     m_data_tvalid,
  input  wire fsi_out_t m_data_pay,
  output logic          m_data_tready,
  // Capture
  output int            n_got,
  output fsi_out_t      got
);
  // Ready held low only while the bench asks for a stall
  assign m_data_tready = !stall;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      n_got <= 0;
      got   <= '0;
    end else if (m_data_tvalid && (m_data_tready || no_ready)) begin
      n_got <= n_got + 1;
      got   <= m_data_pay;
    end
  end
endmodule : fsi_sink

// file: dv/fir_stream_interface_config_bench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module fir_stream_interface_config_bench import fsi_pkg::*;;
  logic sys_clk = 0, rst = 1, aresetn_n = 1, clk_en = 1, stall = 0;
  fsi_rate_t rate_mode = FSI_NONE;
  logic [RATE_W-1:0] rate_fac = ONE_RATE;
  logic pkt_last_mode = 1, pkt_sync = 0, cfg_single = 1, out_has_ready = 1;
  logic s_data_tvalid = 0, s_data_tready, m_data_tvalid, m_data_tready;
  logic s_cfg_tvalid = 0, s_cfg_tready, reload_done = 0, reload_tready;
  logic reload_activate, ev_cfg_last_missing, ev_cfg_last_unexp;
  fsi_in_t  s_data_pay = '0;
  fsi_out_t m_data_pay, got;
  fsi_cfg_t s_cfg_pay = '0;
  logic [NUM_CHAN*FSEL_W-1:0] fsel_out;
  int n_mismatch = 0, comparisons = 0, n_got, n_miss = 0, n_unexp = 0;

  always #4 sys_clk = ~sys_clk;

  fsi_core u_fsi_core (.sys_clk(sys_clk), .rst(rst), .aresetn_n(aresetn_n), .clk_en(clk_en),
    .rate_mode(rate_mode), .rate_fac(rate_fac), .pkt_last_mode(pkt_last_mode),
    .pkt_sync(pkt_sync), .cfg_single(cfg_single), .out_has_ready(out_has_ready),
    .s_data_tvalid(s_data_tvalid), .s_data_pay(s_data_pay), .s_data_tready(s_data_tready),
    .m_data_tvalid(m_data_tvalid), .m_data_pay(m_data_pay), .m_data_tready(m_data_tready),
    .s_cfg_tvalid(s_cfg_tvalid), .s_cfg_pay(s_cfg_pay), .s_cfg_tready(s_cfg_tready),
    .reload_done(reload_done), .reload_tready(reload_tready), .fsel_out(fsel_out),
    .reload_activate(reload_activate), .ev_cfg_last_missing(ev_cfg_last_missing),
    .ev_cfg_last_unexp(ev_cfg_last_unexp));
  fsi_sink u_fsi_sink (.sys_clk(sys_clk), .rst(rst), .stall(stall), .no_ready(!out_has_ready),
    .m_data_tvalid(m_data_tvalid), .m_data_pay(m_data_pay), .m_data_tready(m_data_tready),
    .n_got(n_got), .got(got));

  // Event pulses counted per high cycle
  always @(posedge sys_clk) begin
    if (ev_cfg_last_missing === 1'b1) n_miss++;
    if (ev_cfg_last_unexp === 1'b1) n_unexp++;
  end

  function automatic logic [OUT_PAD-1:0] ext(input logic [PATH_W-1:0] p);
    return {{(OUT_PAD-PATH_W){p[PATH_W-1]}}, p};
  endfunction : ext

  // ****************************************
  // Drivers
  // ****************************************
  // Padding bits carry junk on purpose; the block must ignore them
  task automatic send(input logic [CHAN_W-1:0] ch, input logic [USER_W-1:0] us,
                      input logic lst, input logic [PATH_W-1:0] p0, p1, input int hold);
    int seen;
    s_data_pay = '{data: {5'h15, p1, 5'h0A, p0}, user: {us, ch}, last: lst};
    s_data_tvalid = 1;
    if (hold > 0) begin
      seen = n_got;
      clk_en = 0;
      repeat (hold) @(negedge sys_clk);
      `CHK("frozen out valid", 1'b0, m_data_tvalid)
      `CHK("frozen count", seen, n_got)
      clk_en = 1;
    end
    while (s_data_tready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
    s_data_tvalid = 0;
    s_data_pay = ~s_data_pay;
  endtask : send

  task automatic cfg(input logic [FSEL_W-1:0] fs, input logic lst);
    s_cfg_pay = '{data: {5'h00, fs}, last: lst};
    s_cfg_tvalid = 1;
    while (s_cfg_tready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
    s_cfg_tvalid = 0;
    s_cfg_pay = ~s_cfg_pay;
    @(negedge sys_clk);
  endtask : cfg

  task automatic soft_reset();
    aresetn_n = 0;
    repeat (2) @(negedge sys_clk);
    `CHK("soft rst data ready", 1'b0, s_data_tready)
    `CHK("soft rst cfg ready", 1'b0, s_cfg_tready)
    aresetn_n = 1;
    repeat (2) @(negedge sys_clk);
    `CHK("cfg ready back", 1'b1, s_cfg_tready)
  endtask : soft_reset

  task automatic chk_out(input logic [TUSER_W-1:0] eu, input logic el, input logic dchk,
                         input logic [PATH_W-1:0] p0, p1);
    `CHK("out valid", 1'b1, m_data_tvalid)
    `CHK("out user", eu, m_data_pay.user[OTUSER_W-1:1])
    `CHK("out last", el, m_data_pay.last)
    if (dchk) `CHK("out data", {ext(p1), ext(p0)}, m_data_pay.data)
    @(negedge sys_clk);
  endtask : chk_out

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_pass();
    send(2'h0, 4'h9, 1'b1, 11'h400, 11'h123, 0);
    chk_out({4'h9, 2'h0}, 1'b1, 1'b1, 11'h400, 11'h123);
    send(2'h3, 4'h6, 1'b0, 11'h7FF, 11'h001, 3);
    `CHK("data valid", 1'b1, m_data_pay.user[0])
    chk_out({4'h6, 2'h3}, 1'b0, 1'b1, 11'h7FF, 11'h001);
  endtask : t_pass

  task automatic t_stall();
    int seen;
    stall = 1;
    send(2'h1, 4'hC, 1'b1, 11'h2AA, 11'h555, 0);
    seen = n_got;
    repeat (2) @(negedge sys_clk);
    `CHK("stall in ready", 1'b0, s_data_tready)
    `CHK("stall out valid", 1'b1, m_data_tvalid)
    chk_out({4'hC, 2'h1}, 1'b1, 1'b1, 11'h2AA, 11'h555);
    stall = 0;
    @(negedge sys_clk);
    `CHK("drained count", seen + 1, n_got)
    out_has_ready = 0;
    stall = 1;
    seen = n_got;
    send(2'h0, 4'h2, 1'b0, 11'h001, 11'h002, 0);
    `CHK("no ready out valid", 1'b1, m_data_tvalid)
    @(negedge sys_clk);
    `CHK("no ready taken", seen + 1, n_got)
    `CHK("no ready in ready", 1'b1, s_data_tready)
    stall = 0;
    out_has_ready = 1;
  endtask : t_stall

  // Reload slots filled, then one config packet frees them
  task automatic t_cfg();
    int k;
    soft_reset();
    repeat (4) begin
      reload_done = 1;
      @(negedge sys_clk);
      reload_done = 0;
      @(negedge sys_clk);
    end
    `CHK("slots full ready", 1'b0, reload_tready)
    cfg(3'h5, 1'b0);
    send(2'h0, 4'h1, 1'b0, 11'h010, 11'h020, 0);
    k = 0;
    while (reload_activate !== 1'b1 && k < 4) begin
      @(negedge sys_clk);
      k++;
    end
    `CHK("activate", 1'b1, reload_activate)
    `CHK("fsel all", {NUM_CHAN{3'h5}}, fsel_out)
    @(negedge sys_clk);
    `CHK("activate pulse", 1'b0, reload_activate)
    `CHK("slots freed", 1'b1, reload_tready)
  endtask : t_cfg

  task automatic t_rate();
    rate_mode = FSI_DECIM;
    rate_fac = 4'h2;
    send(2'h0, 4'h3, 1'b1, 11'h011, 11'h022, 0);
    @(negedge sys_clk);
    send(2'h1, 4'h7, 1'b0, 11'h033, 11'h044, 0);
    chk_out({4'h3, 2'h0}, 1'b1, 1'b0, 11'h000, 11'h000);
    rate_mode = FSI_INTERP;
    send(2'h2, 4'h5, 1'b1, 11'h066, 11'h077, 0);
    chk_out({4'h5, 2'h2}, 1'b1, 1'b0, 11'h000, 11'h000);
    rate_mode = FSI_NONE;
    rate_fac = ONE_RATE;
  endtask : t_rate

  // Queued config waits for an input last, then one packet at the next vector start
  task automatic t_fill();
    int n;
    pkt_sync = 1;
    soft_reset();
    n = 0;
    s_cfg_pay = '{data: 8'h03, last: 1'b0};
    s_cfg_tvalid = 1;
    repeat (10) begin
      if (s_cfg_tready === 1'b1) n++;
      @(negedge sys_clk);
    end
    s_cfg_tvalid = 0;
    `CHK("cfg beats held", CFG_AFULL, n)
    pkt_last_mode = 0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      send(CHAN_W'(c), 4'h0, c == NUM_CHAN - 1, 11'h000, 11'h000, 0);
      `CHK("vector last", c == NUM_CHAN - 1, m_data_pay.last)
      @(negedge sys_clk);
    end
    `CHK("fsel kept", {NUM_CHAN{3'h5}}, fsel_out)
    send(2'h0, 4'h0, 1'b0, 11'h000, 11'h000, 0);
    `CHK("sync activate", 1'b1, reload_activate)
    `CHK("fsel queued", {NUM_CHAN{3'h3}}, fsel_out)
    pkt_last_mode = 1;
    pkt_sync = 0;
  endtask : t_fill

  task automatic t_events();
    cfg_single = 0;
    soft_reset();
    repeat (4) cfg(3'h2, 1'b0);
    repeat (3) @(negedge sys_clk);
    `CHK("missing pulses", 1, n_miss)
    soft_reset();
    cfg(3'h1, 1'b1);
    repeat (3) @(negedge sys_clk);
    `CHK("unexpected pulses", 1, n_unexp)
    cfg_single = 1;
  endtask : t_events

  task automatic results();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 0;
    repeat (2) @(negedge sys_clk);
    t_pass();
    t_stall();
    t_cfg();
    t_rate();
    t_fill();
    t_events();
    results();
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    results();
  end
endmodule : fir_stream_interface_config_bench
